//--- hdl/irq_wake.sv
// Serial port interrupt, address detect and wake-up block
// Functional notes
// - six conditions feed one port request
// - request is an active-low pulse
// - own transmit enables, shared receive enable
// - status flags read-only, set by port
// - address detect interrupts without own flag
// - receive falling edge wakes when clock off
// - address mode needs top bit set
// - without address mode every word interrupts
// - transmitter freezes while clock off
// - receiver holds while clock off
// - registers unchanged across idle or sleep
// - wake armed by four bits, clock off
// - received data discarded during recovery
// - without enables wake only, no interrupt
// - wake interrupt waits for recovery end
// - vector needs global, port, stack room
// - avail cleared by status then data read
// - overrun interrupts through receive enable
module irq_wake
    import irq_wake_pkg::*;
#(
    parameter int REC_CYC = WAKE_REC_CYC  // Wake recovery cycles
) (
    input  wire logic       clk,          // 20 MHz clock
    input  wire logic       rstn,         // Sync reset, low
    input  wire logic       wb_cyc_i,     // Bus cycle
    input  wire logic       wb_stb_i,     // Bus strobe
    input  wire logic       wb_we_i,      // Write enable
    input  wire logic [7:0] wb_adr_i,     // Byte address
    input  wire logic [3:0] wb_sel_i,     // Byte selects
    input  wire logic [31:0] wb_dat_i,    // Write data
    output logic      [31:0] wb_dat_o,    // Read data
    output logic            wb_ack_o,     // Acknowledge
    input  wire logic       rx_pin,       // Receive line
    input  wire logic       fast_clk_on,  // Fast clock running
    input  wire logic       stack_full,   // Return stack full
    input  wire logic       tx_empty,     // Tx data reg empty
    input  wire logic       tx_idle,      // Transmitter idle
    input  wire logic       rx_word_done, // Word received pulse
    input  wire logic [8:0] rx_word,      // Received word
    output logic            irq_n,        // Port request, low
    output logic            wake_req,     // Wake pulse
    output logic            core_hold,    // Freeze tx and rx
    output logic            rx_discard,   // Drop received data
    output logic [7:0]      baud_div,     // Baud divider
    output logic            nine_bit_select, // Nine-bit words
    output logic            parity_on     // Parity enable
);

    // Software registers
    logic [2:0] ctrl1_q;
    logic [5:0] ctrl2_q;
    logic [7:0] baud_q;
    logic [1:0] irqctl_q;
    logic [8:0] data_q;
    logic       avail_q;
    logic       ovr_q;
    logic       seen_q;
    // Bus answer
    logic        ack_q;
    logic [31:0] rdat_q;
    // Pin synchroniser and level
    logic       rx_s1_q;
    logic       rx_s2_q;
    logic       rx_s3_q;
    logic       rx_lvl_q;
    // Transmit level history
    logic       txe_prev_q;
    logic       txi_prev_q;
    // Wake sequencer
    wake_state_t wst_q;
    wake_state_t wst_d;
    logic [15:0] rec_cnt_q;
    logic [15:0] rec_cnt_d;
    logic        wake_irq_q;
    // Output flops
    logic       irq_n_q;
    logic       wake_req_q;
    logic       hold_q;
    logic       discard_q;

    // Top received bit picks bit 8 or bit 7
    function automatic logic top_bit(input logic nine, input logic [8:0] w);
        top_bit = nine ? w[8] : w[7];
    endfunction : top_bit

    // Field decode
    wire addr_mode    = ctrl2_q[C2_ADDR];
    wire rx_irq_en    = ctrl2_q[C2_RX_EN];
    wire wake_en      = ctrl2_q[C2_WAKE];
    wire receiver_on  = ctrl2_q[C2_RCV_ON];
    wire serial_unit_on = ctrl1_q[C1_UNIT];
    wire global_irq_en  = irqctl_q[IC_GLOBAL];
    wire port_irq_en    = irqctl_q[IC_PORT];

    // Bus decode; the answer comes one cycle after the request
    wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr       = req & wb_we_i & wb_sel_i[0];
    wire rd       = req & ~wb_we_i;
    wire hit_st   = wb_adr_i == OFS_STATUS;
    wire hit_c1   = wb_adr_i == OFS_CTRL1;
    wire hit_c2   = wb_adr_i == OFS_CTRL2;
    wire hit_data = wb_adr_i == OFS_DATA;
    wire hit_baud = wb_adr_i == OFS_BAUD;
    wire hit_ic   = wb_adr_i == OFS_IRQCTL;

    // Recovery window blocks new words
    // drop during recovery
    wire in_recov = wst_q == W_RECOV;
    wire word_ok  = rx_word_done & ~in_recov & ~hold_q;

    // Status then data read clears the receive flags
    // ordered clear
    wire st_access = req & hit_st;
    wire data_rd   = rd & hit_data & seen_q;

    // Status word, built from live state
    logic [4:0] status_w;
    assign status_w[ST_TXE]   = tx_empty;
    assign status_w[ST_TXI]   = tx_idle;
    assign status_w[ST_AVAIL] = avail_q;
    assign status_w[ST_OVR]   = ovr_q;
    assign status_w[ST_WAKE]  = in_recov;

    // Read data select, unmapped reads as zero
    wire [31:0] rsel =
        hit_st   ? {27'h0, status_w} :
        hit_c1   ? {29'h0, ctrl1_q}  :
        hit_c2   ? {26'h0, ctrl2_q}  :
        hit_data ? {23'h0, data_q}   :
        hit_baud ? {24'h0, baud_q}   :
        hit_ic   ? {30'h0, irqctl_q} : 32'h0;

    // Pin edge: level moves only when stages two and three agree
    wire rx_agree = rx_s2_q == rx_s3_q;
    wire rx_fall  = rx_agree & ~rx_s3_q & rx_lvl_q;

    wire wake_armed = wake_en & serial_unit_on & receiver_on
                    & rx_irq_en & ~fast_clk_on;
    wire wake_hit = wake_armed & rx_fall & (wst_q == W_IDLE);

    // Interrupt sources
    // own transmit enables
    wire ev_txe = ctrl2_q[C2_TXE_EN] & tx_empty & ~txe_prev_q;
    wire ev_txi = ctrl2_q[C2_TXI_EN] & tx_idle & ~txi_prev_q;
    wire is_addr = top_bit(ctrl1_q[C1_NINE], rx_word);
    wire ev_rx   = rx_irq_en & word_ok & (~addr_mode | is_addr);
    wire ev_ovr  = rx_irq_en & word_ok & avail_q;
    wire ev_addr = addr_mode & word_ok & is_addr;
    wire rec_end = in_recov & (rec_cnt_q == 16'h0000);
    wire ev_wake = rec_end & wake_irq_q;

    wire any_ev = ev_txe | ev_txi | ev_rx | ev_ovr | ev_addr | ev_wake;
    wire vec_ok = global_irq_en & port_irq_en & ~stack_full;

    // Wake sequencer next state
    always_comb begin
        wst_d     = wst_q;
        rec_cnt_d = rec_cnt_q;
        case (wst_q)
            W_IDLE: begin
                if (wake_hit) begin
                    wst_d     = W_RECOV;
                    rec_cnt_d = 16'(REC_CYC - 1);
                end
            end
            W_RECOV: begin
                // Count only once the fast clock is back
                if (rec_cnt_q == 16'h0000) begin
                    wst_d = W_IDLE;
                end else if (fast_clk_on) begin
                    rec_cnt_d = rec_cnt_q - 16'h0001;
                end
            end
            default: begin
                wst_d     = W_IDLE;
                rec_cnt_d = 16'h0000;
            end
        endcase
    end

    // Wake sequencer state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wst_q     <= W_IDLE;
            rec_cnt_q <= 16'h0000;
        end else begin
            wst_q     <= wst_d;
            rec_cnt_q <= rec_cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wake_irq_q <= 1'b0;
        end else if (wake_hit) begin
            wake_irq_q <= global_irq_en & port_irq_en;
        end else if (rec_end) begin
            wake_irq_q <= 1'b0;
        end
    end

    // Pin synchroniser, three stages
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_s1_q  <= 1'b1;
            rx_s2_q  <= 1'b1;
            rx_s3_q  <= 1'b1;
            rx_lvl_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            if (rx_agree) begin
                rx_lvl_q <= rx_s3_q;
            end
        end
    end

    // Transmit level history for edge-based events
    always_ff @(posedge clk) begin
        if (!rstn) begin
            txe_prev_q <= 1'b0;
            txi_prev_q <= 1'b0;
        end else begin
            txe_prev_q <= tx_empty;
            txi_prev_q <= tx_idle;
        end
    end

    // Control registers; writes only, clock gating never touches them
    // contents kept
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl1_q  <= CTRL1_RST;
            ctrl2_q  <= CTRL2_RST;
            baud_q   <= BAUD_RST;
            irqctl_q <= IRQCTL_RST;
        end else if (wr) begin
            if (hit_c1) ctrl1_q <= wb_dat_i[2:0];
            if (hit_c2) ctrl2_q <= wb_dat_i[5:0];
            if (hit_baud) baud_q <= wb_dat_i[7:0];
            if (hit_ic) irqctl_q <= wb_dat_i[1:0];
        end
    end

    // Receive flags; a new word beats a same-cycle clear
    // flags set by port only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_q  <= 9'h000;
            avail_q <= 1'b0;
            ovr_q   <= 1'b0;
            seen_q  <= 1'b0;
        end else begin
            if (word_ok & ~avail_q) begin
                data_q <= rx_word;
            end
            if (word_ok) begin
                avail_q <= 1'b1;
            end else if (data_rd) begin
                avail_q <= 1'b0;
            end
            if (word_ok & avail_q) begin
                ovr_q <= 1'b1;
            end else if (data_rd) begin
                ovr_q <= 1'b0;
            end
            if (st_access) begin
                seen_q <= 1'b1;
            end else if (data_rd) begin
                seen_q <= 1'b0;
            end
        end
    end

    // Bus answer; every request is acked, unmapped included
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            ack_q  <= req;
            rdat_q <= rd ? rsel : 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_n_q    <= 1'b1;
            wake_req_q <= 1'b0;
        end else begin
            irq_n_q    <= ~(any_ev & vec_ok);
            wake_req_q <= wake_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_q    <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            hold_q    <= ~fast_clk_on;
            discard_q <= wst_d == W_RECOV;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o        = ack_q;
    assign wb_dat_o        = rdat_q;
    assign irq_n           = irq_n_q;
    assign wake_req        = wake_req_q;
    assign core_hold       = hold_q;
    assign rx_discard      = discard_q;
    assign baud_div        = baud_q;
    assign nine_bit_select = ctrl1_q[C1_NINE];
    assign parity_on       = ctrl1_q[C1_PARITY];

endmodule : irq_wake

//--- hdl/irq_wake_pkg.sv
// Constants for the serial port interrupt and wake logic
package irq_wake_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL1  = 8'h04;
    localparam logic [7:0] OFS_CTRL2  = 8'h08;
    localparam logic [7:0] OFS_DATA   = 8'h0c;
    localparam logic [7:0] OFS_BAUD   = 8'h10;
    localparam logic [7:0] OFS_IRQCTL = 8'h14;
    // Status bits
    localparam int ST_TXE   = 0;
    localparam int ST_TXI   = 1;
    localparam int ST_AVAIL = 2;
    localparam int ST_OVR   = 3;
    localparam int ST_WAKE  = 4;
    // Control one bits
    localparam int C1_NINE   = 0;
    localparam int C1_PARITY = 1;
    localparam int C1_UNIT   = 2;
    // Control two bits
    localparam int C2_TXE_EN = 0;
    localparam int C2_TXI_EN = 1;
    localparam int C2_RX_EN  = 2;
    localparam int C2_ADDR   = 3;
    localparam int C2_RCV_ON = 4;
    localparam int C2_WAKE   = 5;
    // Interrupt control bits
    localparam int IC_GLOBAL = 0;
    localparam int IC_PORT   = 1;
    // Reset values
    localparam logic [2:0] CTRL1_RST  = 3'h0;
    localparam logic [5:0] CTRL2_RST  = 6'h00;
    localparam logic [7:0] BAUD_RST   = 8'h00;
    localparam logic [1:0] IRQCTL_RST = 2'h0;
    // Wake recovery time and clock
    localparam int CLK_HZ       = 20_000_000;
    localparam int WAKE_REC_NS  = 1000;
    localparam int WAKE_REC_CYC =
        (WAKE_REC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Wake sequencer states
    typedef enum logic [1:0] {
        W_IDLE  = 2'b01,
        W_RECOV = 2'b10
    } wake_state_t;
endpackage : irq_wake_pkg

//--- verification/irq_wake_chk.sv
// Port assertions for the interrupt and wake block
module irq_wake_chk #(
    parameter int REC_CYC = 3  // Wake recovery cycles
) (
    input wire logic clk,          // Clock
    input wire logic rstn,         // Sync reset, low
    input wire logic rx_word_done, // Word pulse
    input wire logic tx_empty,     // Tx reg empty
    input wire logic tx_idle,      // Tx idle
    input wire logic fast_clk_on,  // Fast clock on
    input wire logic stack_full,   // Stack full
    input wire logic irq_n,        // Request, low
    input wire logic wake_req,     // Wake pulse
    input wire logic core_hold,    // Freeze
    input wire logic rx_discard    // Drop data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Freeze tracks the clock; the first cycle after reset is skipped
    AST_HOLD: assert property ($past(rstn) |-> core_hold == !$past(fast_clk_on))
        else $error("hold does not follow the stopped clock");
    AST_WAKE_OFF: assert property ($rose(wake_req) |-> !$past(fast_clk_on))
        else $error("wake with the clock running");
    AST_WAKE_PULSE: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    AST_WAKE_DISC: assert property (wake_req |-> rx_discard)
        else $error("no discard at wake");
    AST_DISC_START: assert property ($rose(rx_discard) |-> wake_req)
        else $error("discard without wake");
    // A word in recovery raises no request in the next cycle while discard still holds
    AST_DISC_DROP: assert property (rx_discard && rx_word_done && !tx_empty && !tx_idle
        |=> irq_n || !rx_discard)
        else $error("word in recovery raised a request");
    AST_IRQ_CAUSE: assert property (!irq_n |-> $past(rx_word_done) || $past(tx_empty)
        || $past(tx_idle) || $fell(rx_discard))
        else $error("request without a cause");
    AST_IRQ_STACK: assert property (!irq_n |-> !$past(stack_full))
        else $error("request with the stack full");
    AST_REC_CLK: assert property ($fell(rx_discard) |-> $past(fast_clk_on, 2))
        else $error("recovery ended with the clock off");
endmodule : irq_wake_chk

bind irq_wake irq_wake_chk #(.REC_CYC(REC_CYC)) i_irq_wake_chk (.clk(clk), .rstn(rstn),
    .rx_word_done(rx_word_done), .tx_empty(tx_empty), .tx_idle(tx_idle), .fast_clk_on(fast_clk_on),
    .stack_full(stack_full), .irq_n(irq_n), .wake_req(wake_req), .core_hold(core_hold), .rx_discard(rx_discard));

//--- verification/irq_wake_tb_top.sv
// Testbench for the serial port interrupt and wake block
module irq_wake_tb_top
    import irq_wake_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, cyc, stb, we, rx_done, fclk, sfull, txe, txi;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [8:0]  rword;
    wire  [31:0] rdat;
    wire  [7:0]  baud;
    wire         ack, irq_n, wake_req, hold, discard, rx_pin, nine, par;
    int          failures, checked, irqs, wakes;
    irq_wake #(.REC_CYC(3)) i_irq_wake (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_pin(rx_pin),
        .fast_clk_on(fclk), .stack_full(sfull), .tx_empty(txe), .tx_idle(txi), .rx_word_done(rx_done),
        .rx_word(rword), .irq_n(irq_n), .wake_req(wake_req), .core_hold(hold), .rx_discard(discard),
        .baud_div(baud), .nine_bit_select(nine), .parity_on(par));
    rx_line_model i_rx_line_model (.clk(clk), .rx_pin(rx_pin));
    // Clock at 20 MHz
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Pulse counters for the request and wake outputs
    always @(posedge clk) begin
        if (irq_n === 1'b0) irqs++;
        if (wake_req === 1'b1) wakes++;
    end
    task automatic end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One classic cycle; the answer latency is not assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask : rd
    // Status access then data read empties the receive side
    task automatic clr;
        logic [31:0] q;
        bus(1'b0, OFS_STATUS, 32'h0, q);
        bus(1'b0, OFS_DATA, 32'h0, q);
    endtask : clr
    task automatic cnt(input string what, input int exp, input int b);
        repeat (3) @(posedge clk);
        chk(what, exp, irqs - b);
    endtask : cnt
    task automatic word(input logic [8:0] v, input string what, input int exp);
        int b;
        b = irqs;
        @(posedge clk);
        rx_done <= 1'b1;
        rword   <= v;
        @(posedge clk);
        rx_done <= 1'b0;
        cnt(what, exp, b);
    endtask : word
    task automatic tx(input logic e, input logic i, input string what, input int exp);
        int b;
        b = irqs;
        @(posedge clk);
        txe <= e;
        txi <= i;
        cnt(what, exp, b);
    endtask : tx
    task automatic t_regs;
        rd("ctrl2 rst", OFS_CTRL2, 32'(CTRL2_RST));
        wr(OFS_BAUD, 32'h5a);
        wr(OFS_STATUS, 32'h1f);
        rd("status ro", OFS_STATUS, 32'h0);
        rd("unmapped", 8'h20, 32'h0);
        chk("baud pin", 32'h5a, 32'(baud));
        wr(OFS_CTRL1, 32'h2);
        chk("parity pin on", 32'h1, 32'(par));
    endtask : t_regs
    task automatic t_rx;
        rd("data idle", OFS_DATA, 32'h0);
        wr(OFS_IRQCTL, 32'h3);
        wr(OFS_CTRL2, 32'h04);
        word(9'h0a5, "rx irq", 1);
        word(9'h033, "ovr irq", 1);
        rd("data kept", OFS_DATA, 32'h0a5);
        rd("status ovr", OFS_STATUS, 32'h0c);
        rd("data", OFS_DATA, 32'h0a5);
        rd("status clr", OFS_STATUS, 32'h0);
        wr(OFS_CTRL2, 32'h00);
        word(9'h011, "rx masked", 0);
        clr();
    endtask : t_rx
    task automatic t_addr;
        wr(OFS_CTRL1, 32'h0);
        chk("parity pin off", 32'h0, 32'(par));
        wr(OFS_CTRL2, 32'h0c);
        word(9'h17f, "addr8 low", 0);
        clr();
        wr(OFS_CTRL2, 32'h08);
        word(9'h080, "addr8 high", 1);
        clr();
        wr(OFS_CTRL1, 32'h1);
        chk("nine pin", 32'h1, 32'(nine));
        word(9'h0ff, "addr9 low", 0);
        clr();
        word(9'h100, "addr9 high", 1);
        clr();
    endtask : t_addr
    task automatic t_tx;
        wr(OFS_CTRL2, 32'h01);
        tx(1'b1, 1'b0, "txe", 1);
        tx(1'b1, 1'b1, "txi masked", 0);
        tx(1'b0, 1'b0, "tx low", 0);
        wr(OFS_CTRL2, 32'h03);
        sfull <= 1'b1;
        tx(1'b1, 1'b1, "stack full", 0);
        sfull <= 1'b0;
        tx(1'b0, 1'b0, "tx low", 0);
        tx(1'b1, 1'b1, "two at once", 1);
        wr(OFS_IRQCTL, 32'h1);
        tx(1'b0, 1'b0, "tx low", 0);
        tx(1'b1, 1'b0, "port off", 0);
        tx(1'b0, 1'b0, "tx low", 0);
    endtask : t_tx
    task automatic t_wake(input logic [31:0] ic, input int exp);
        int b;
        int w;
        wr(OFS_IRQCTL, ic);
        wr(OFS_CTRL1, 32'h4);
        wr(OFS_CTRL2, 32'h24);
        // Nothing is in flight when the clock stops
        fclk <= 1'b0;
        repeat (3) @(posedge clk);
        chk("hold", 32'h1, 32'(hold));
        w = wakes;
        b = irqs;
        i_rx_line_model.start_bit(6);
        cnt("receiver off", 0, b);
        chk("no wake", 32'(w), 32'(wakes));
        wr(OFS_CTRL2, 32'h34);
        b = irqs;
        i_rx_line_model.start_bit(6);
        cnt("held back", 0, b);
        chk("wake", 32'(w + 1), 32'(wakes));
        chk("discard", 32'h1, 32'(discard));
        word(9'h055, "word dropped", 0);
        fclk <= 1'b1;
        w = 0;
        while (irqs == b && w < 30) begin
            @(posedge clk);
            w++;
        end
        cnt("wake irq", exp, b);
        rd("status after", OFS_STATUS, 32'h0);
        rd("baud kept", OFS_BAUD, 32'h5a);
    endtask : t_wake
    initial begin
        rstn = 1'b0;
        fclk = 1'b1;
        {cyc, stb, we, rx_done, sfull, txe, txi} = '0;
        {adr, wdat, rword} = '0;
        failures = 0;
        checked = 0;
        irqs = 0;
        wakes = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_rx();
        t_addr();
        t_tx();
        t_wake(32'h3, 1);
        t_wake(32'h0, 0);
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        #500_000;
        failures++;
        end_sim();
    end
endmodule : irq_wake_tb_top

//--- verification/rx_line_model.sv
// Remote transmitter driving the receive line
module rx_line_model (
    input  wire logic clk,    // Bench clock
    output logic      rx_pin  // Line, idles high
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rx_pin = 1'b1;
    // Start bit: low for n cycles, then idle again
    task automatic start_bit(input int n);
        @(posedge clk);
        rx_pin <= 1'b0;
        repeat (n) @(posedge clk);
        rx_pin <= 1'b1;
    endtask : start_bit
endmodule : rx_line_model
